/* File: input_pga_gain_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pga_defs.svh"

module input_pga_gain_control
  import pga_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `ZC_TIMEOUT_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic mode_pin, // high selects three-wire port
  input wire logic sclk_pin, // control port clock
  input wire logic sdin_in, // control port data in
  input wire logic csb_pin, // three-wire latch strobe
  output logic sdin_out, // open-drain data, always low
  output logic sdin_oe, // pulls data low while high
  input wire logic left_sign_pin, // left signal polarity comparator
  input wire logic right_sign_pin, // right signal polarity comparator
  input wire logic [5:0] alc_left_gain, // level loop gain, left
  input wire logic [5:0] alc_right_gain, // level loop gain, right
  output logic left_pga_on, // left stage power
  output logic right_pga_on, // right stage power
  output logic left_plus_route, // plus pin to left stage
  output logic left_minus_route, // minus pin to left stage
  output logic left_aux_route, // aux pin to left stage
  output logic right_plus_route, // plus pin to right stage
  output logic right_minus_route, // minus pin to right stage
  output logic right_aux_route, // aux pin to right stage
  output logic [5:0] left_pga_gain, // left gain code in effect
  output logic [5:0] right_pga_gain, // right gain code in effect
  output logic left_pga_silence, // left stage muted
  output logic right_pga_silence, // right stage muted
  output logic [1:0] level_control_select // level control select
);

  // the tick counter is 24 bits wide
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << 24)) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end

  ctl_state_s q, d;
  logic scl_rise, scl_fall, start_c, stop_c, csb_rise, three_wire;
  logic wr;
  logic [6:0] wa;
  logic [8:0] wd;
  logic [8:0] rd;
  logic [7:0] tx_load;
  logic [1:0][5:0] applied;
  logic [1:0] busy;

  // ==========================================================
  // read-back, commit bit never stored
  always_comb begin
    rd = 9'h000;
    if (q.ptr == `REG_POWER_TWO) begin
      rd[`LEFT_PGA_ON_BIT] = q.pga_on[1];
      rd[`RIGHT_PGA_ON_BIT] = q.pga_on[0];
    end else if (q.ptr == `REG_LEVEL_ONE) begin
      rd[`LEVEL_SEL_MSB:`LEVEL_SEL_LSB] = q.level_sel;
    end else if (q.ptr == `REG_ROUTING) begin
      rd[6:0] = q.route;
    end else if (q.ptr == `REG_LEFT_GAIN) begin
      rd[7:0] = q.gctl[1];
    end else if (q.ptr == `REG_RIGHT_GAIN) begin
      rd[7:0] = q.gctl[0];
    end
  end

  // ==========================================================
  // control port and register file
  always_comb begin
    d = q;
    wr = 1'b0;
    wa = 7'h00;
    wd = 9'h000;
    d.scl_s = {q.scl_s[1:0], sclk_pin};
    d.sda_s = {q.sda_s[1:0], sdin_in};
    d.csb_s = {q.csb_s[1:0], csb_pin};
    d.mode_s = {q.mode_s[0], mode_pin};
    d.sign_s[1] = {q.sign_s[1][0], left_sign_pin};
    d.sign_s[0] = {q.sign_s[0][0], right_sign_pin};
    scl_rise = q.scl_s[1] & ~q.scl_s[2];
    scl_fall = ~q.scl_s[1] & q.scl_s[2];
    start_c = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
    stop_c = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];
    csb_rise = q.csb_s[1] & ~q.csb_s[2];
    three_wire = q.mode_s[1];
    d.commit = 1'b0;
    if (q.nbyte == 2'd1) begin
      tx_load = {q.ptr, rd[8]};
    end else if (q.nbyte == 2'd2) begin
      tx_load = rd[7:0];
    end else begin
      tx_load = 8'h00;
    end

    if (three_wire) begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
      if (scl_rise) begin
        d.sh = {q.sh[14:0], q.sda_s[1]};
      end
      if (csb_rise) begin
        wr = 1'b1;
        wa = q.sh[15:9];
        wd = q.sh[8:0];
      end
    end else if (start_c) begin
      d.st = ST_ADDR;
      d.bitn = 4'd0;
      d.nbyte = 2'd0;
      d.oe = 1'b0;
    end else if (stop_c) begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE, ST_SKIP: begin
          d.oe = 1'b0;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise && q.bitn != 4'd8) begin
            d.sh = {q.sh[14:0], q.sda_s[1]};
            d.bitn = q.bitn + 4'd1;
          end else if (scl_fall && q.bitn == 4'd8) begin
            d.bitn = 4'd0;
            if (q.st == ST_ADDR) begin
              if (q.sh[7:1] == `DEV_ADDR) begin
                d.rw = q.sh[0];
                d.oe = 1'b1;
                d.st = ST_ACK;
                d.nbyte = 2'd1;
              end else begin
                d.st = ST_SKIP;
              end
            end else begin
              d.oe = 1'b1;
              d.st = ST_ACK;
              if (q.nbyte == 2'd1) begin
                d.ptr = q.sh[7:1];
                d.nbyte = 2'd2;
              end else if (q.nbyte == 2'd2) begin
                wr = 1'b1;
                wa = q.sh[15:9];
                wd = q.sh[8:0];
                d.nbyte = 2'd3;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              d.tx = tx_load;
              d.oe = ~tx_load[7];
              d.bitn = 4'd1;
              d.st = ST_RDATA;
              d.nbyte = (q.nbyte == 2'd3) ? 2'd3 : q.nbyte + 2'd1;
            end else begin
              d.oe = 1'b0;
              d.st = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (q.bitn == 4'd8) begin
              d.oe = 1'b0;
              d.st = ST_RACK;
            end else begin
              d.tx = {q.tx[6:0], 1'b0};
              d.oe = ~q.tx[6];
              d.bitn = q.bitn + 4'd1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            d.st = q.sda_s[1] ? ST_SKIP : ST_ACK;
          end
        end
      endcase
    end

    if (wr) begin
      d.ptr = wa;
      if (wa == `REG_POWER_TWO) begin
        d.pga_on = {wd[`LEFT_PGA_ON_BIT], wd[`RIGHT_PGA_ON_BIT]};
      end else if (wa == `REG_LEVEL_ONE) begin
        d.level_sel = wd[`LEVEL_SEL_MSB:`LEVEL_SEL_LSB];
      end else if (wa == `REG_ROUTING) begin
        d.route = wd[6:0] & `ROUTE_MASK;
      end else if (wa == `REG_LEFT_GAIN || wa == `REG_RIGHT_GAIN) begin
        d.gctl[(wa == `REG_LEFT_GAIN) ? 1 : 0] = wd[7:0];
        d.commit = wd[`COMMIT_BIT];
      end
    end

    // free-running period; a commit lands anywhere inside it
    d.tick = 1'b0;
    if (q.tmo_cnt == 24'(TIMEOUT_CYCLES - 1)) begin
      d.tmo_cnt = 24'h000000;
      d.tick = 1'b1;
    end else begin
      d.tmo_cnt = q.tmo_cnt + 24'h000001;
    end

    d.gain_o[1] = q.level_sel[1] ? alc_left_gain : applied[1];
    d.gain_o[0] = q.level_sel[0] ? alc_right_gain : applied[0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.csb_s <= 3'h7;
      q.pga_on <= `PGA_ON_RESET;
      q.route <= `ROUTE_RESET;
      q.level_sel <= `LEVEL_SEL_RESET;
      q.gctl <= {`GAIN_CTL_RESET, `GAIN_CTL_RESET};
      q.gain_o <= {`GAIN_RESET, `GAIN_RESET};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // per-channel gain apply, shared commit and timeout
  for (genvar c = 0; c < 2; c++) begin : g_ch
    gain_apply #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_apply (
      .clk(clk),
      .rst(rst),
      .pending_gain(q.gctl[c][`GAIN_MSB:0]),
      .zero_cross_en(q.gctl[c][`ZERO_CROSS_BIT]),
      .commit(q.commit),
      .sign_sync(q.sign_s[c][1]),
      .timeout_tick(q.tick),
      .applied_gain(applied[c]),
      .busy(busy[c])
    );
  end

  assign sdin_out = 1'b0;
  assign sdin_oe = q.oe;
  assign left_pga_on = q.pga_on[1];
  assign right_pga_on = q.pga_on[0];
  assign left_plus_route = q.route[0];
  assign left_minus_route = q.route[1];
  assign left_aux_route = q.route[2];
  assign right_plus_route = q.route[4];
  assign right_minus_route = q.route[5];
  assign right_aux_route = q.route[6];
  assign left_pga_gain = q.gain_o[1];
  assign right_pga_gain = q.gain_o[0];
  assign left_pga_silence = q.gctl[1][`SILENCE_BIT];
  assign right_pga_silence = q.gctl[0][`SILENCE_BIT];
  assign level_control_select = q.level_sel;

  // ==========================================================
  // checks
  property p_power;
    @(posedge clk) disable iff (rst)
    wr && wa == `REG_POWER_TWO |=> left_pga_on == $past(wd[2]) && right_pga_on == $past(wd[3]);
  endproperty
  a_power: assert property (p_power) else $error("power bit not taken");

  property p_route;
    @(posedge clk) disable iff (rst)
    wr && wa == `REG_ROUTING |=> left_aux_route == $past(wd[2]) && right_plus_route == $past(wd[4]);
  endproperty
  a_route: assert property (p_route) else $error("routing bit not taken");

  property p_silence;
    @(posedge clk) disable iff (rst)
    wr && wa == `REG_LEFT_GAIN |=> left_pga_silence == $past(wd[6]);
  endproperty
  a_silence: assert property (p_silence) else $error("silence bit not taken");

  property p_pending;
    @(posedge clk) disable iff (rst)
    !q.commit && !busy[1] |=> applied[1] == $past(applied[1]);
  endproperty
  a_pending: assert property (p_pending) else $error("gain moved without commit");

  property p_select;
    @(posedge clk) disable iff (rst)
    wr && wa == `REG_LEVEL_ONE |=> level_control_select == $past(wd[8:7]);
  endproperty
  a_select: assert property (p_select) else $error("select not taken");

  property p_alc_follow;
    @(posedge clk) disable iff (rst)
    q.level_sel[1] |=> left_pga_gain == $past(alc_left_gain);
  endproperty
  a_alc_follow: assert property (p_alc_follow) else $error("left gain not under level loop");

  property p_addr;
    @(posedge clk) disable iff (rst)
    !three_wire && q.st == ST_ADDR && scl_fall && q.bitn == 4'd8 && q.sh[7:1] != `DEV_ADDR |=> !sdin_oe;
  endproperty
  a_addr: assert property (p_addr) else $error("acked foreign address");

  property p_commit_zero;
    @(posedge clk) disable iff (rst)
    q.ptr == `REG_LEFT_GAIN || q.ptr == `REG_RIGHT_GAIN |-> rd[8] == 1'b0;
  endproperty
  a_commit_zero: assert property (p_commit_zero) else $error("commit bit read back");

endmodule : input_pga_gain_control
`default_nettype wire

/* File: pga_defs.svh */
`ifndef PGA_DEFS_SVH
`define PGA_DEFS_SVH

// ==========================================================
// register offsets on the control port
`define REG_POWER_TWO 7'h02
`define REG_LEVEL_ONE 7'h20
`define REG_ROUTING 7'h2c
`define REG_LEFT_GAIN 7'h2d
`define REG_RIGHT_GAIN 7'h2e

// ==========================================================
// field positions
`define LEFT_PGA_ON_BIT 2
`define RIGHT_PGA_ON_BIT 3
`define GAIN_MSB 5
`define SILENCE_BIT 6
`define ZERO_CROSS_BIT 7
`define COMMIT_BIT 8
`define LEVEL_SEL_MSB 8
`define LEVEL_SEL_LSB 7
`define ROUTE_MASK 7'h77

// ==========================================================
// reset values
`define ROUTE_RESET 7'h33
`define GAIN_CTL_RESET 8'h10
`define GAIN_RESET 6'h10
`define PGA_ON_RESET 2'h0
`define LEVEL_SEL_RESET 2'h0

// ==========================================================
// two-wire bus address and timing
`define DEV_ADDR 7'h1a
`define CLK_PERIOD_NS 10
`define ZC_TIMEOUT_US 1000
`define ZC_TIMEOUT_CYCLES (`ZC_TIMEOUT_US * 1000 / `CLK_PERIOD_NS)

`endif

/* File: pga_pkg.sv */
package pga_pkg;

  // ==========================================================
  // control port sequencer states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_ACK   = 7'b0000100,
    ST_WDATA = 7'b0001000,
    ST_RDATA = 7'b0010000,
    ST_RACK  = 7'b0100000,
    ST_SKIP  = 7'b1000000
  } link_state_e;

  // ==========================================================
  // top-level state; channel index 1 is left, 0 is right
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] csb_s;
    logic [1:0] mode_s;
    logic [1:0][1:0] sign_s;
    link_state_e st;
    logic [3:0] bitn;
    logic [1:0] nbyte;
    logic rw;
    logic [15:0] sh;
    logic [7:0] tx;
    logic [6:0] ptr;
    logic oe;
    logic [1:0] pga_on;
    logic [6:0] route;
    logic [1:0] level_sel;
    logic [1:0][7:0] gctl;
    logic commit;
    logic [23:0] tmo_cnt;
    logic tick;
    logic [1:0][5:0] gain_o;
  } ctl_state_s;

  // ==========================================================
  // per-channel gain apply state
  typedef struct packed {
    logic [5:0] held;
    logic [5:0] applied;
    logic waiting;
    logic tick_seen;
    logic sign_prev;
  } apply_state_s;

endpackage : pga_pkg

/* File: gain_apply.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pga_defs.svh"

module gain_apply
  import pga_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `ZC_TIMEOUT_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [5:0] pending_gain, // gain field as written
  input wire logic zero_cross_en, // wait for zero crossing
  input wire logic commit, // one-cycle commit strobe
  input wire logic sign_sync, // synchronised signal polarity
  input wire logic timeout_tick, // one pulse per timeout period
  output logic [5:0] applied_gain, // gain in effect
  output logic busy // update waiting
);

  // two ticks per wait need a period of at least two cycles
  if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end

  apply_state_s q, d;
  logic zc_seen;
  int unsigned wait_cnt;

  always_comb begin
    d = q;
    d.sign_prev = sign_sync;
    zc_seen = sign_sync != q.sign_prev;
    if (commit) begin
      d.held = pending_gain;
      d.tick_seen = 1'b0;
      if (zero_cross_en) begin
        d.waiting = 1'b1;
      end else begin
        d.applied = pending_gain;
        d.waiting = 1'b0;
      end
    end else if (q.waiting) begin
      // first tick may come at once; second guarantees a full period
      if (zc_seen || (timeout_tick && q.tick_seen)) begin
        d.applied = q.held;
        d.waiting = 1'b0;
      end else if (timeout_tick) begin
        d.tick_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{held: `GAIN_RESET, applied: `GAIN_RESET, waiting: 1'b0, tick_seen: 1'b0, sign_prev: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign applied_gain = q.applied;
  assign busy = q.waiting;

  // ==========================================================
  // checks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= q.waiting ? wait_cnt + 1 : 0;
    end
  end

  property p_no_zc_immediate;
    @(posedge clk) disable iff (rst)
    commit && !zero_cross_en |=> applied_gain == $past(pending_gain) && !busy;
  endproperty
  a_no_zc_immediate: assert property (p_no_zc_immediate) else $error("gain not applied at once");

  property p_zc_waits;
    @(posedge clk) disable iff (rst)
    commit && zero_cross_en |=> busy && applied_gain == $past(applied_gain);
  endproperty
  a_zc_waits: assert property (p_zc_waits) else $error("zero-cross update not deferred");

  property p_timeout_bound;
    @(posedge clk) disable iff (rst)
    busy |-> wait_cnt < 2 * TIMEOUT_CYCLES + 2;
  endproperty
  a_timeout_bound: assert property (p_timeout_bound) else $error("timeout did not force update");

endmodule : gain_apply
`default_nettype wire

/* File: control_host.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// control port host, driving at the falling clock edge
module control_host (
  input wire logic clk, // system clock
  input wire logic sdin_oe, // device pulls data low
  output logic mode_pin, // port select
  output logic sclk_pin, // port clock
  output logic csb_pin, // three-wire latch
  output logic sdin_wire // resolved data line
);
  logic sda_low;

  // pull-up: a released line reads high, never the last value
  assign sdin_wire = ~(sda_low | sdin_oe);

  initial begin
    mode_pin = 1'b1;
    sclk_pin = 1'b1;
    csb_pin = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold

  task automatic set_mode(input logic m);
    mode_pin = m;
    hold(8);
  endtask : set_mode

  // data moves only while the clock is low
  task automatic bit_out(input logic b);
    sclk_pin = 1'b0;
    hold(2);
    sda_low = ~b;
    hold(4);
    sclk_pin = 1'b1;
    hold(4);
  endtask : bit_out

  task automatic write3(input logic [6:0] a, input logic [8:0] d);
    logic [15:0] w;
    w = {a, d};
    csb_pin = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      bit_out(w[i]);
    end
    hold(2);
    csb_pin = 1'b1;
    sda_low = 1'b0;
    hold(2);
  endtask : write3

  task automatic byte_out(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    sclk_pin = 1'b0;
    hold(2);
    sda_low = 1'b0;
    hold(4);
    sclk_pin = 1'b1;
    hold(2);
    ack = ~sdin_wire;
    hold(2);
  endtask : byte_out

  task automatic write2(input logic [6:0] dev, input logic [6:0] a, input logic [8:0] d, output logic ok);
    logic a1;
    logic a2;
    logic a3;
    sda_low = 1'b1;
    hold(4);
    byte_out({dev, 1'b0}, a1);
    byte_out({a, d[8]}, a2);
    byte_out(d[7:0], a3);
    stop_bus();
    ok = a1;
  endtask : write2

  // data rises while the clock is high
  task automatic stop_bus();
    sclk_pin = 1'b0;
    hold(2);
    sda_low = 1'b1;
    hold(4);
    sclk_pin = 1'b1;
    hold(4);
    sda_low = 1'b0;
    hold(6);
  endtask : stop_bus

  // line released; sampled late in the high phase, then host ack or nack
  task automatic byte_in(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_out(1'b1);
      b[i] = sdin_wire;
    end
    bit_out(~more);
  endtask : byte_in

  task automatic read2(input logic [6:0] dev, output logic [15:0] w, output logic ok);
    logic [7:0] hi;
    logic [7:0] lo;
    sda_low = 1'b1;
    hold(4);
    byte_out({dev, 1'b1}, ok);
    byte_in(1'b1, hi);
    byte_in(1'b0, lo);
    stop_bus();
    w = {hi, lo};
  endtask : read2
endmodule : control_host

`default_nettype wire

/* File: test_input_pga_gain_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_input_pga_gain_control;
  import pga_pkg::*;
  localparam int TMO = 16;
  logic clk;
  logic rst;
  logic mode_pin, sclk_pin, csb_pin, sdin_wire, sdin_out, sdin_oe;
  logic left_sign;
  logic right_sign;
  logic [5:0] alc_l;
  logic [5:0] alc_r;
  logic lpo, rpo, lp, lm, la, rp, rm, ra, ls, rs;
  logic [5:0] lg, rg;
  logic [1:0] sel;
  int errors = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  control_host control_host_inst (.clk(clk), .sdin_oe(sdin_oe), .mode_pin(mode_pin), .sclk_pin(sclk_pin),
    .csb_pin(csb_pin), .sdin_wire(sdin_wire));

  input_pga_gain_control #(.TIMEOUT_CYCLES(TMO)) input_pga_gain_control_inst (.clk(clk), .rst(rst),
    .mode_pin(mode_pin), .sclk_pin(sclk_pin), .sdin_in(sdin_wire), .csb_pin(csb_pin), .sdin_out(sdin_out),
    .sdin_oe(sdin_oe), .left_sign_pin(left_sign), .right_sign_pin(right_sign), .alc_left_gain(alc_l),
    .alc_right_gain(alc_r), .left_pga_on(lpo), .right_pga_on(rpo), .left_plus_route(lp),
    .left_minus_route(lm), .left_aux_route(la), .right_plus_route(rp), .right_minus_route(rm),
    .right_aux_route(ra), .left_pga_gain(lg), .right_pga_gain(rg), .left_pga_silence(ls),
    .right_pga_silence(rs), .level_control_select(sel));

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // bounded wait for both applied gains; a miss ends the run
  task automatic wait_gain(input logic [5:0] el, input logic [5:0] er, input int bound, output int n);
    n = 0;
    while ({lg, rg} !== {el, er} && n < bound) begin
      @(negedge clk);
      n++;
    end
    check(9'({lg, rg} === {el, er}), 9'h001);
    if ({lg, rg} !== {el, er}) begin
      finish_test();
    end
  endtask : wait_gain

  task automatic t_reset();
    check(9'({lpo, rpo}), 9'h000);
    check(9'({ra, rm, rp, la, lm, lp}), 9'h01b);
    check(9'(lg), 9'h010);
    check(9'(rg), 9'h010);
    check(9'({ls, rs, sel, sdin_oe, sdin_out}), 9'h000);
  endtask : t_reset

  task automatic t_power();
    logic [8:0] tbl [4] = '{9'h004, 9'h008, 9'h1f3, 9'h00c};
    foreach (tbl[i]) begin
      control_host_inst.write3(7'h02, tbl[i]);
      control_host_inst.hold(4);
      check(9'({lpo, rpo}), 9'({tbl[i][2], tbl[i][3]}));
    end
  endtask : t_power

  task automatic t_route();
    logic [8:0] tbl [2] = '{9'h044, 9'h1bb};
    foreach (tbl[i]) begin
      control_host_inst.write3(7'h2c, tbl[i]);
      control_host_inst.hold(4);
      check(9'({ra, rm, rp, la, lm, lp}), 9'({tbl[i][6:4], tbl[i][2:0]}));
    end
    // unmapped place leaves every routing output alone
    control_host_inst.write3(7'h2f, 9'h000);
    control_host_inst.hold(4);
    check(9'({ra, rm, rp, la, lm, lp}), 9'h01b);
  endtask : t_route

  task automatic t_commit();
    int n;
    control_host_inst.write3(7'h2d, 9'h03f);
    control_host_inst.hold(6);
    check(9'(lg), 9'h010);
    control_host_inst.write3(7'h2e, 9'h100);
    wait_gain(6'h3f, 6'h00, 8, n);
    control_host_inst.write3(7'h2d, 9'h02a);
    control_host_inst.hold(8);
    check(9'(lg), 9'h03f);
    control_host_inst.write3(7'h2d, 9'h12a);
    wait_gain(6'h2a, 6'h00, 8, n);
  endtask : t_commit

  task automatic t_silence();
    control_host_inst.write3(7'h2d, 9'h06a);
    control_host_inst.hold(4);
    check(9'({ls, rs}), 9'h002);
    control_host_inst.write3(7'h2e, 9'h040);
    control_host_inst.write3(7'h2d, 9'h02a);
    control_host_inst.hold(4);
    check(9'({ls, rs}), 9'h001);
    control_host_inst.write3(7'h2e, 9'h000);
    control_host_inst.hold(4);
    check(9'({ls, rs, lg}), 9'h02a);
  endtask : t_silence

  task automatic t_zero_cross();
    int n;
    control_host_inst.write3(7'h2d, 9'h1bf);
    check(9'(lg), 9'h02a);
    wait_gain(6'h3f, 6'h00, 2 * TMO + 12, n);
    check(9'(n >= TMO), 9'h001);
    control_host_inst.write3(7'h2e, 9'h1a0);
    control_host_inst.hold(2);
    check(9'(rg), 9'h000);
    right_sign = 1'b1;
    wait_gain(6'h3f, 6'h20, 9, n);
    control_host_inst.write3(7'h2d, 9'h1a5);
    control_host_inst.hold(2);
    check(9'(lg), 9'h03f);
    left_sign = 1'b1;
    wait_gain(6'h25, 6'h20, 9, n);
  endtask : t_zero_cross

  task automatic t_level();
    int n;
    // manual gain fields left untouched while the loop is in charge
    for (int s = 0; s < 4; s++) begin
      control_host_inst.write3(7'h20, {2'(s), 7'h00});
      control_host_inst.hold(4);
      check(9'(sel), 9'(s));
      check(9'(lg), 9'(s[1] ? 6'h15 : 6'h25));
      check(9'(rg), 9'(s[0] ? 6'h0b : 6'h20));
    end
    alc_l = 6'h01;
    alc_r = 6'h2c;
    wait_gain(6'h01, 6'h2c, 4, n);
    control_host_inst.write3(7'h20, 9'h000);
    wait_gain(6'h25, 6'h20, 4, n);
  endtask : t_level

  task automatic t_two_wire();
    logic ok;
    logic [15:0] w;
    control_host_inst.set_mode(1'b0);
    control_host_inst.write2(7'h1a, 7'h02, 9'h008, ok);
    check(9'(ok), 9'h001);
    check(9'({lpo, rpo}), 9'h001);
    control_host_inst.write2(7'h1b, 7'h02, 9'h00c, ok);
    check(9'({ok, lpo, rpo}), 9'h001);
    control_host_inst.write2(7'h1a, 7'h2d, 9'h13f, ok);
    check(9'(lg), 9'h03f);
    control_host_inst.read2(7'h1a, w, ok);
    check(9'(ok), 9'h001);
    check(9'(w[15:8]), 9'h05a);
    check(9'(w[7:0]), 9'h03f);
  endtask : t_two_wire

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    left_sign = 1'b0;
    right_sign = 1'b0;
    alc_l = 6'h15;
    alc_r = 6'h0b;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    control_host_inst.hold(4);
    t_reset();
    t_power();
    t_route();
    t_commit();
    t_silence();
    t_zero_cross();
    t_level();
    t_two_wire();
    finish_test();
  end
endmodule : test_input_pga_gain_control

`default_nettype wire
